// ### touch_cfg_pkg.sv
// touch_cfg_pkg: register map, field layout and reset values of the
// touch acquisition configuration register block.
// assumes: a 32-bit apb bus with byte addresses, one word per register.
package touch_cfg_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] DISCHARGE_SOURCE_CONTROL_OFFSET = 8'h5c;
  localparam logic [7:0] SPREAD_SPECTRUM_CONFIG_OFFSET = 8'h60;
  localparam logic [7:0] SENSE_A_DRIVE_CONTROL_OFFSET = 8'h64;
  localparam logic [7:0] SENSE_B_DRIVE_CONTROL_OFFSET = 8'h68;
  localparam logic [7:0] AUTONOMOUS_BASELINE_COUNT_OFFSET = 8'h6c;
  localparam logic [7:0] AUTONOMOUS_CURRENT_COUNT_OFFSET = 8'h70;
  localparam logic [7:0] TOUCH_STATE_WRITE_OFFSET = 8'h78;
  localparam logic [7:0] TOUCH_STATE_READBACK_OFFSET = 8'h7c;

  // ************************************************************
  // field layout of the discharge source control register
  // ************************************************************
  localparam int SOURCE_COUNT = 8;
  localparam int SOURCE_ENABLE_LSB = 0;
  localparam int TRIM_LSB = 8;
  localparam int TRIM_WIDTH = 5;
  localparam int REF_RESISTOR_SELECT_BIT = 16;
  localparam int REF_VOLTAGE_SELECT_BIT = 17;
  localparam int GLOBAL_SOURCE_ENABLE_BIT = 23;
  localparam int CURRENT_SINK_FORCE_LSB = 24;

  // ************************************************************
  // other fields
  // ************************************************************
  localparam int SPREAD_PEAK_SHIFT_WIDTH = 8;
  localparam int SENSE_LINE_COUNT = 17;
  localparam int TALLY_WIDTH = 16;
  localparam int IDLE_TALLY_LSB = 0;
  localparam int DETECT_TALLY_LSB = 16;
  localparam int DETECT_TALLY_WIDTH = 8;
  localparam int SKIP_CALIBRATION_BIT = 24;
  localparam int TOUCH_STATE_WIDTH = 25;

  // ************************************************************
  // reset values and spread-spectrum generator constants
  // ************************************************************
  localparam logic [31:0] DISCHARGE_SOURCE_CONTROL_RESET = 32'h0000_0000;
  localparam logic [7:0] SPREAD_SPECTRUM_CONFIG_RESET = 8'h00;
  localparam logic [31:0] SENSE_DRIVE_CONTROL_RESET = 32'h0000_0000;
  localparam logic [24:0] TOUCH_STATE_RESET = 25'h000_0000;
  localparam logic [15:0] SPREAD_LFSR_SEED = 16'hace1;
  localparam logic [15:0] SPREAD_LFSR_TAPS = 16'hb400;
  localparam int PRESCALE_DIVIDE_DEFAULT = 4;

endpackage : touch_cfg_pkg

// ### touch_acquisition_config_regs.sv
// touch_acquisition_config_regs: apb register block that configures the
// discharge current sources, reference, spread-spectrum deviation and
// resistive sense drive of a capacitive touch acquisition unit, and that
// carries the detection algorithm state to and from software.
// assumes: one clock, the acquisition engine drives the phase and count
// inputs synchronous to clk_sys, and the analog side decodes the trim.

`timescale 1ns/1ps
`default_nettype none

module touch_acquisition_config_regs #(
  parameter int SENSE_LINES = touch_cfg_pkg::SENSE_LINE_COUNT,
  parameter int PRESCALE_DIVIDE = touch_cfg_pkg::PRESCALE_DIVIDE_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // acquisition engine phases
  input wire logic acquisition_window,
  input wire logic burst_phase,
  input wire logic spread_enable,
  input wire logic burst_start,
  // autonomous sensor counts
  input wire logic [15:0] auto_base_count,
  input wire logic [15:0] auto_current_count,
  // detection algorithm state exchange
  input wire logic state_update,
  input wire logic [24:0] state_update_data,
  output logic state_load,
  output logic [24:0] state_load_data,
  // analog current source controls
  output logic [7:0] source_on,
  output logic global_source_enable,
  output logic ref_voltage_select,
  output logic ref_resistor_select,
  output logic [4:0] source_trim,
  // spread-spectrum burst deviation
  output logic [7:0] spread_peak_shift,
  output logic burst_shift_lengthen,
  output logic [7:0] burst_shift_cycles,
  // resistive sense drive
  output logic [SENSE_LINES-1:0] sense_line_a_soft,
  output logic [SENSE_LINES-1:0] sense_line_b_soft
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the drive registers are one word wide and the prescaler needs a tick
  if (SENSE_LINES < 1 || SENSE_LINES > 32) begin : g_bad_lines
    $error("SENSE_LINES must lie between 1 and 32");
  end
  if (PRESCALE_DIVIDE < 1 || PRESCALE_DIVIDE > 255) begin : g_bad_div
    $error("PRESCALE_DIVIDE must lie between 1 and 255");
  end

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_n;
  logic rst_sync_n;

  // asynchronous assertion, release after two edges
  // the first flop feeds only the second, never the datapath
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ************************************************************
  // state of the block
  // ************************************************************
  typedef struct packed {
    logic [7:0] force_bits;
    logic global_en;
    logic vref_sel;
    logic rref_sel;
    logic [4:0] trim;
    logic [7:0] source_en;
    logic [7:0] peak_shift;
    logic [SENSE_LINES-1:0] drive_a;
    logic [SENSE_LINES-1:0] drive_b;
    logic [24:0] state_wr;
    logic [24:0] state_rb;
    logic state_load;
    logic [7:0] source_on;
    logic [SENSE_LINES-1:0] soft_a;
    logic [SENSE_LINES-1:0] soft_b;
    logic [15:0] lfsr;
    logic [7:0] prescale;
    logic shift_lengthen;
    logic [7:0] shift_cycles;
    logic [31:0] prdata;
    logic pslverr;
  } regs_t;

  regs_t state_reg;
  regs_t state_next;

  // ************************************************************
  // per-line gating
  // ************************************************************
  logic [7:0] source_on_next;
  logic [SENSE_LINES-1:0] soft_a_next;
  logic [SENSE_LINES-1:0] soft_b_next;

  // the global enable overrides even a forced source
  // a forced source stays on outside acquisition windows: test use only
  for (genvar n = 0; n < touch_cfg_pkg::SOURCE_COUNT; n++) begin : g_source
    assign source_on_next[n] = state_reg.global_en
      & (state_reg.force_bits[n]
      | (state_reg.source_en[n] & acquisition_window));
  end

  // soft drive only applies while the burst is running
  for (genvar n = 0; n < SENSE_LINES; n++) begin : g_sense
    assign soft_a_next[n] = state_reg.drive_a[n] & burst_phase;
    assign soft_b_next[n] = state_reg.drive_b[n] & burst_phase;
  end

  // ************************************************************
  // apb decode
  // ************************************************************
  logic setup_phase;
  logic write_access;
  logic addr_mapped;
  logic [31:0] read_word;
  logic [31:0] discharge_word;
  logic [31:0] drive_a_word;
  logic [31:0] drive_b_word;

  assign setup_phase = psel & ~penable;
  assign write_access = psel & penable & pwrite;

  // assemble the discharge control word, unused bits stay zero
  // reserved bits 22:18 and 15:13 are never assigned, so a write of ones
  // there cannot leak back on a read
  always_comb begin
    discharge_word = 32'h0000_0000;
    discharge_word[touch_cfg_pkg::CURRENT_SINK_FORCE_LSB +: 8] =
      state_reg.force_bits;
    discharge_word[touch_cfg_pkg::GLOBAL_SOURCE_ENABLE_BIT] =
      state_reg.global_en;
    discharge_word[touch_cfg_pkg::REF_VOLTAGE_SELECT_BIT] =
      state_reg.vref_sel;
    discharge_word[touch_cfg_pkg::REF_RESISTOR_SELECT_BIT] =
      state_reg.rref_sel;
    discharge_word[touch_cfg_pkg::TRIM_LSB +: touch_cfg_pkg::TRIM_WIDTH] =
      state_reg.trim;
    discharge_word[touch_cfg_pkg::SOURCE_ENABLE_LSB +: 8] =
      state_reg.source_en;
    drive_a_word = 32'h0000_0000;
    drive_a_word[SENSE_LINES-1:0] = state_reg.drive_a;
    drive_b_word = 32'h0000_0000;
    drive_b_word[SENSE_LINES-1:0] = state_reg.drive_b;
  end

  // read mux, evaluated in the setup cycle so prdata can be a flop
  always_comb begin
    read_word = 32'h0000_0000;
    addr_mapped = 1'b1;
    case (paddr)
      touch_cfg_pkg::DISCHARGE_SOURCE_CONTROL_OFFSET: begin
        read_word = discharge_word;
      end
      touch_cfg_pkg::SPREAD_SPECTRUM_CONFIG_OFFSET: begin
        read_word[7:0] = state_reg.peak_shift;
      end
      touch_cfg_pkg::SENSE_A_DRIVE_CONTROL_OFFSET: begin
        read_word = drive_a_word;
      end
      touch_cfg_pkg::SENSE_B_DRIVE_CONTROL_OFFSET: begin
        read_word = drive_b_word;
      end
      touch_cfg_pkg::AUTONOMOUS_BASELINE_COUNT_OFFSET: begin
        read_word[15:0] = auto_base_count;
      end
      touch_cfg_pkg::AUTONOMOUS_CURRENT_COUNT_OFFSET: begin
        read_word[15:0] = auto_current_count;
      end
      touch_cfg_pkg::TOUCH_STATE_WRITE_OFFSET: begin
        read_word = 32'h0000_0000;
      end
      touch_cfg_pkg::TOUCH_STATE_READBACK_OFFSET: begin
        read_word[24:0] = state_reg.state_rb;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // spread-spectrum deviation
  // ************************************************************
  logic prescale_tick;
  logic [7:0] raw_shift;
  logic [15:0] lfsr_step;

  // the deviation source steps once per prescaled clock cycle
  // a slower step saves switching power but repeats deviations more often
  assign prescale_tick =
    (state_reg.prescale == 8'(PRESCALE_DIVIDE - 1));
  assign lfsr_step = state_reg.lfsr[0]
    ? ((state_reg.lfsr >> 1) ^ touch_cfg_pkg::SPREAD_LFSR_TAPS)
    : (state_reg.lfsr >> 1);
  assign raw_shift = state_reg.lfsr[7:0];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.state_load = 1'b0;
    state_next.source_on = source_on_next;
    state_next.soft_a = soft_a_next;
    state_next.soft_b = soft_b_next;

    // prescaler and pseudo-random deviation source
    if (prescale_tick) begin
      state_next.prescale = 8'h00;
      state_next.lfsr = lfsr_step;
    end else begin
      state_next.prescale = state_reg.prescale + 8'h01;
    end

    // clamp the deviation so a burst never moves by more than the limit
    // the sign bit lies outside the clamped byte, so it stays unbiased
    if (burst_start) begin
      if (spread_enable) begin
        state_next.shift_lengthen = state_reg.lfsr[15];
        state_next.shift_cycles = (raw_shift > state_reg.peak_shift)
          ? state_reg.peak_shift : raw_shift;
      end else begin
        state_next.shift_lengthen = 1'b0;
        state_next.shift_cycles = 8'h00;
      end
    end

    // read data and error are captured in the setup cycle
    if (setup_phase) begin
      state_next.prdata = pwrite ? 32'h0000_0000 : read_word;
      state_next.pslverr = ~addr_mapped;
    end

    // writes take effect at the access edge; unused bits are dropped
    if (write_access) begin
      case (paddr)
        touch_cfg_pkg::DISCHARGE_SOURCE_CONTROL_OFFSET: begin
          state_next.force_bits =
            pwdata[touch_cfg_pkg::CURRENT_SINK_FORCE_LSB +: 8];
          state_next.global_en =
            pwdata[touch_cfg_pkg::GLOBAL_SOURCE_ENABLE_BIT];
          state_next.vref_sel =
            pwdata[touch_cfg_pkg::REF_VOLTAGE_SELECT_BIT];
          state_next.rref_sel =
            pwdata[touch_cfg_pkg::REF_RESISTOR_SELECT_BIT];
          state_next.trim = pwdata[touch_cfg_pkg::TRIM_LSB +:
            touch_cfg_pkg::TRIM_WIDTH];
          state_next.source_en =
            pwdata[touch_cfg_pkg::SOURCE_ENABLE_LSB +: 8];
        end
        touch_cfg_pkg::SPREAD_SPECTRUM_CONFIG_OFFSET: begin
          state_next.peak_shift = pwdata[7:0];
        end
        touch_cfg_pkg::SENSE_A_DRIVE_CONTROL_OFFSET: begin
          state_next.drive_a = pwdata[SENSE_LINES-1:0];
        end
        touch_cfg_pkg::SENSE_B_DRIVE_CONTROL_OFFSET: begin
          state_next.drive_b = pwdata[SENSE_LINES-1:0];
        end
        touch_cfg_pkg::TOUCH_STATE_WRITE_OFFSET: begin
          // hand the new state to the algorithm with a one-cycle strobe
          state_next.state_wr = pwdata[24:0];
          state_next.state_load = 1'b1;
        end
        touch_cfg_pkg::TOUCH_STATE_READBACK_OFFSET: begin
          state_next.state_rb = pwdata[24:0];
        end
        default: begin
          state_next.state_load = 1'b0;
        end
      endcase
    end

    // algorithm update wins over a software write in the same cycle
    // software that races the algorithm loses its write and must reread
    // the readback register to see which value stuck
    if (state_update) begin
      state_next.state_rb = state_update_data;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // only the synchronised copy resets the state, so a release close to an
  // edge cannot leave half of the fields out of reset
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= '0;
      state_reg.force_bits <= touch_cfg_pkg::DISCHARGE_SOURCE_CONTROL_RESET
        [touch_cfg_pkg::CURRENT_SINK_FORCE_LSB +: 8];
      state_reg.source_en <= touch_cfg_pkg::DISCHARGE_SOURCE_CONTROL_RESET
        [touch_cfg_pkg::SOURCE_ENABLE_LSB +: 8];
      state_reg.peak_shift <= touch_cfg_pkg::SPREAD_SPECTRUM_CONFIG_RESET;
      state_reg.drive_a <=
        touch_cfg_pkg::SENSE_DRIVE_CONTROL_RESET[SENSE_LINES-1:0];
      state_reg.drive_b <=
        touch_cfg_pkg::SENSE_DRIVE_CONTROL_RESET[SENSE_LINES-1:0];
      state_reg.state_wr <= touch_cfg_pkg::TOUCH_STATE_RESET;
      state_reg.state_rb <= touch_cfg_pkg::TOUCH_STATE_RESET;
      state_reg.lfsr <= touch_cfg_pkg::SPREAD_LFSR_SEED; // never all zero
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // zero wait states: data was captured in the setup cycle
  // a count input that moves during the access cycle shows on the next read
  // only; the trade buys a flopped read bus with no wait states
  assign pready = 1'b1;
  assign prdata = state_reg.prdata;
  assign pslverr = state_reg.pslverr;

  // analog controls straight from flops
  assign source_on = state_reg.source_on;
  assign global_source_enable = state_reg.global_en;
  assign ref_voltage_select = state_reg.vref_sel;
  assign ref_resistor_select = state_reg.rref_sel;
  assign source_trim = state_reg.trim;
  assign spread_peak_shift = state_reg.peak_shift;
  assign burst_shift_lengthen = state_reg.shift_lengthen;
  assign burst_shift_cycles = state_reg.shift_cycles;
  assign sense_line_a_soft = state_reg.soft_a;
  assign sense_line_b_soft = state_reg.soft_b;
  assign state_load = state_reg.state_load;
  assign state_load_data = state_reg.state_wr;

endmodule : touch_acquisition_config_regs

`default_nettype wire

// ### touch_acquisition_config_regs_checker.sv
// checker: port-level assertions for the touch configuration registers
// assumes: bound into the register block, zero-wait apb, one clock
`timescale 1ns/1ps
`default_nettype none
module touch_acquisition_config_regs_checker #(
  parameter int SENSE_LINES = 17
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // engine side and outputs
  input wire logic acquisition_window,
  input wire logic burst_phase,
  input wire logic burst_start,
  input wire logic [15:0] auto_base_count,
  input wire logic state_load,
  input wire logic [24:0] state_load_data,
  input wire logic [7:0] source_on,
  input wire logic ref_voltage_select,
  input wire logic ref_resistor_select,
  input wire logic [4:0] source_trim,
  input wire logic [7:0] spread_peak_shift,
  input wire logic [7:0] burst_shift_cycles,
  input wire logic [SENSE_LINES-1:0] sense_line_a_soft,
  input wire logic [SENSE_LINES-1:0] sense_line_b_soft
);
  // ********************
  // shadow of software writes
  // ********************
  logic [2:0] live_reg;
  logic [31:0] discharge_reg;
  logic [SENSE_LINES-1:0] drive_a_reg, drive_b_reg, soft_a_exp, soft_b_exp;
  logic [7:0] on_exp;
  logic wr;
  // expected outputs one cycle ahead of the block's registers
  assign wr = psel && penable && pwrite;
  assign on_exp = {8{discharge_reg[23]}} &
    (discharge_reg[31:24] |
    (discharge_reg[7:0] & {8{acquisition_window}}));
  assign soft_a_exp = drive_a_reg & {SENSE_LINES{burst_phase}};
  assign soft_b_exp = drive_b_reg & {SENSE_LINES{burst_phase}};
  // live waits out the block's two-flop reset release, plus one edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      live_reg <= 3'h0;
      discharge_reg <= 32'h0000_0000;
      drive_a_reg <= '0;
      drive_b_reg <= '0;
    end else begin
      live_reg <= {live_reg[1:0], 1'b1};
      if (wr && paddr == 8'h5c) discharge_reg <= pwdata;
      if (wr && paddr == 8'h64) drive_a_reg <= pwdata[SENSE_LINES-1:0];
      if (wr && paddr == 8'h68) drive_b_reg <= pwdata[SENSE_LINES-1:0];
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!live_reg[2]);
  a_source_follow:
    assert property (source_on == $past(on_exp))
      else $error("source_on wrong");
  a_ref_trim:
    assert property ({ref_voltage_select, ref_resistor_select, source_trim} ==
      {discharge_reg[17:16], discharge_reg[12:8]})
      else $error("reference outputs wrong");
  a_shift_bound:
    assert property (burst_start |=> burst_shift_cycles <=
      $past(spread_peak_shift)) else $error("burst shift above peak");
  a_soft_a:
    assert property (sense_line_a_soft == $past(soft_a_exp))
      else $error("a soft");
  a_soft_b:
    assert property (sense_line_b_soft == $past(soft_b_exp))
      else $error("b soft");
  a_base_read:
    assert property (psel && penable && !pwrite && paddr == 8'h6c |->
      prdata == {16'h0000, $past(auto_base_count)}) else $error("base read");
  a_state_load:
    assert property (wr && paddr == 8'h78 |=> state_load ##1 !state_load &&
      {7'h00, $past(state_load_data)} == ($past(pwdata, 2) & 32'h01ff_ffff))
    else $error("state load wrong");
  a_wo_zero:
    assert property (psel && penable && !pwrite && paddr == 8'h78 |->
      prdata == 32'h0000_0000) else $error("write-only reads nonzero");
endmodule : touch_acquisition_config_regs_checker

bind touch_acquisition_config_regs touch_acquisition_config_regs_checker #(
  .SENSE_LINES(SENSE_LINES)
) checker_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .acquisition_window(acquisition_window), .burst_phase(burst_phase),
  .burst_start(burst_start), .auto_base_count(auto_base_count),
  .state_load(state_load), .state_load_data(state_load_data),
  .source_on(source_on), .ref_voltage_select(ref_voltage_select),
  .ref_resistor_select(ref_resistor_select), .source_trim(source_trim),
  .spread_peak_shift(spread_peak_shift),
  .burst_shift_cycles(burst_shift_cycles),
  .sense_line_a_soft(sense_line_a_soft), .sense_line_b_soft(sense_line_b_soft)
);
`default_nettype wire

// ### touch_acquisition_config_regs_bench.sv
// bench: directed apb tests of the touch configuration register block
// assumes: the checker is bound in, apb answers with zero wait states
`timescale 1ns/1ps
`default_nettype none
module touch_acquisition_config_regs_bench;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic acquisition_window, burst_phase, spread_enable, burst_start;
  logic state_update, state_load, global_source_enable;
  logic burst_shift_lengthen;
  logic ref_voltage_select, ref_resistor_select;
  logic [7:0] paddr, source_on, spread_peak_shift, burst_shift_cycles;
  logic [31:0] pwdata, prdata, want, seen;
  logic [15:0] auto_base_count, auto_current_count;
  logic [24:0] state_update_data, state_load_data;
  logic [4:0] source_trim;
  logic [16:0] sense_line_a_soft, sense_line_b_soft;
  int fails, checks;
  logic [7:0] addr_tab [8] = '{8'h5c, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h70,
    8'h78, 8'h7c};
  logic [31:0] mask_tab [8] = '{32'hff83_1fff, 32'h0000_00ff, 32'h0001_ffff,
    32'h0001_ffff, 32'h0, 32'h0, 32'h0, 32'h01ff_ffff};
  logic [7:0] bad_tab [3] = '{8'h00, 8'h5d, 8'h74};
  logic [31:0] discharge_tab [4] = '{32'h8180_003c, 32'h0082_1a3c,
    32'hff01_1fff, 32'h0081_0000};
  logic [7:0] peak_tab [2] = '{8'h00, 8'h05};
  // prescale of 1 keeps the deviation generator stepping every cycle
  touch_acquisition_config_regs #(.SENSE_LINES(17), .PRESCALE_DIVIDE(1)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .acquisition_window(acquisition_window), .burst_phase(burst_phase),
    .spread_enable(spread_enable), .burst_start(burst_start),
    .auto_base_count(auto_base_count),
    .auto_current_count(auto_current_count),
    .state_update(state_update), .state_update_data(state_update_data),
    .state_load(state_load), .state_load_data(state_load_data),
    .source_on(source_on), .global_source_enable(global_source_enable),
    .ref_voltage_select(ref_voltage_select),
    .ref_resistor_select(ref_resistor_select), .source_trim(source_trim),
    .spread_peak_shift(spread_peak_shift),
    .burst_shift_lengthen(burst_shift_lengthen),
    .burst_shift_cycles(burst_shift_cycles),
    .sense_line_a_soft(sense_line_a_soft),
    .sense_line_b_soft(sense_line_b_soft)
  );
  // ********************
  // access tasks
  // ********************
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] w,
      input logic [31:0] s);
    checks++;
    if (s !== w) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, w, s);
    end
  endtask : chk
  // one transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      fails++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] w,
      input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", w, r);
    chk("pslverr", 32'(err), 32'(e));
  endtask : rd
  // sample a little after the edge so that its updates have landed
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : look
  task automatic pulse();
    @(posedge clk_sys);
    burst_start <= 1'b1;
    @(posedge clk_sys);
    burst_start <= 1'b0;
    look(1);
  endtask : pulse
  function automatic logic [31:0] discharge_exp(input logic [31:0] d,
      input logic w);
    logic [7:0] on;
    on = {8{d[23]}} & (d[31:24] | (d[7:0] & {8{w}}));
    return {16'h0000, d[23], d[17], d[16], d[12:8], on};
  endfunction : discharge_exp
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {acquisition_window, burst_phase, spread_enable, burst_start} = '0;
    {auto_base_count, auto_current_count, state_update, state_update_data} = '0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (addr_tab[i]) rd(addr_tab[i], 32'h0, 1'b0);
    foreach (addr_tab[i]) wr(addr_tab[i], 32'hffff_ffff);
    foreach (addr_tab[i]) rd(addr_tab[i], mask_tab[i], 1'b0);
    // refused places must not disturb a mapped register
    foreach (bad_tab[i]) begin
      wr(bad_tab[i], 32'h0);
      rd(bad_tab[i], 32'h0, 1'b1);
    end
    rd(8'h5c, 32'hff83_1fff, 1'b0);
    foreach (discharge_tab[i]) begin
      wr(8'h5c, discharge_tab[i]);
      for (int w = 0; w < 2; w++) begin
        @(posedge clk_sys);
        acquisition_window <= w[0];
        look(2);
        want = discharge_exp(discharge_tab[i], w[0]);
        seen = {16'h0000, global_source_enable, ref_voltage_select,
          ref_resistor_select, source_trim, source_on};
        chk("discharge outputs", want, seen);
      end
    end
    wr(8'h64, 32'h0001_0001);
    wr(8'h68, 32'h0000_ff00);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys);
      burst_phase <= b[0];
      look(2);
      want = b[0] ? 32'h0001_0001 : 32'h0;
      chk("soft a", want, 32'(sense_line_a_soft));
      want = b[0] ? 32'h0000_ff00 : 32'h0;
      chk("soft b", want, 32'(sense_line_b_soft));
    end
    @(posedge clk_sys);
    auto_base_count <= 16'h1234;
    auto_current_count <= 16'hbeef;
    spread_enable <= 1'b1;
    rd(8'h6c, 32'h0000_1234, 1'b0);
    rd(8'h70, 32'h0000_beef, 1'b0);
    foreach (peak_tab[i]) begin
      wr(8'h60, 32'(peak_tab[i]));
      look(1);
      chk("peak shift", 32'(peak_tab[i]), 32'(spread_peak_shift));
      repeat (16) begin
        pulse();
        seen = 32'(burst_shift_cycles <= peak_tab[i]);
        chk("shift bound", 32'h1, seen);
      end
    end
    // with spreading off a burst keeps its nominal length and sign
    @(posedge clk_sys);
    spread_enable <= 1'b0;
    pulse();
    seen = {23'h0, burst_shift_lengthen, burst_shift_cycles};
    chk("shift off", 32'h0, seen);
    wr(8'h78, 32'h01a5_5aa5);
    #1;
    seen = {6'h00, state_load, state_load_data};
    chk("state load", 32'h03a5_5aa5, seen);
    look(1);
    chk("state load end", 32'h0, 32'(state_load));
    wr(8'h7c, 32'hfe12_3456);
    rd(8'h7c, 32'h0012_3456, 1'b0);
    @(posedge clk_sys);
    state_update <= 1'b1;
    state_update_data <= 25'h15a_0f0f;
    @(posedge clk_sys);
    state_update <= 1'b0;
    rd(8'h7c, 32'h015a_0f0f, 1'b0);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h5c, 32'h0, 1'b0);
    test_done();
  end
endmodule : touch_acquisition_config_regs_bench
`default_nettype wire
